// ===== hw/term_regs.svh
// Register offsets, field positions, reset values and latency counts.
// Included by bare name from the termination controller.
`ifndef TERM_REGS_SVH
`define TERM_REGS_SVH

`define OFS_MODE_ONE     8'h00
`define OFS_MODE_TWO     8'h04
`define OFS_MODE_FIVE    8'h08
`define OFS_LATENCY      8'h0C
`define OFS_CONTROL      8'h10
`define OFS_STATUS       8'h14

`define NOM_FIELD_LSB    8
`define WR_FIELD_LSB     9
`define PARK_FIELD_LSB   6
`define DYN_BIT_A        9
`define DYN_BIT_B        10

`define CAS_LAT_LSB      0
`define CAS_WR_LAT_LSB   8
`define ADD_LAT_LSB      16
`define PAR_LAT_LSB      24

`define CTL_PRE2         0
`define CTL_CRC          1
`define CTL_BURST_LSB    2
`define CTL_DLL          4
`define CTL_SRF          5

`define MASK_MODE        32'h0000_3FFF
`define MASK_LATENCY     32'h3F3F_3F3F
`define MASK_CONTROL     32'h0000_003F

`define RST_MODE         32'h0000_0000
`define RST_LATENCY      32'h0000_090B
`define RST_CONTROL      32'h0000_0010

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`define PRE1_SUB         8'h02
`define PRE2_SUB         8'h03
`define PRE2_EXTRA       8'h01
`define RD_RESTORE_CHOP  8'h04
`define RD_RESTORE_FULL  8'h06
`define WR_CHOP_ADD      8'h04
`define WR_CHOP_ADD_CRC  8'h07
`define WR_FULL_ADD      8'h06
`define WR_FULL_ADD_CRC  8'h07

`endif

// ===== hw/term_pkg.sv
// Types shared by the termination controller, the controller model and the bench.
// No constants here; numbers live in term_regs.svh.
package term_pkg;

    typedef enum logic [1:0] {
        TERM_OFF  = 2'h0,
        TERM_NOM  = 2'h1,
        TERM_WR   = 2'h2,
        TERM_PARK = 2'h3
    } term_sel_t;

    typedef enum logic [2:0] {
        CMD_NOP               = 3'h0,
        CMD_WRITE             = 3'h1,
        CMD_WRITE_AP          = 3'h2,
        CMD_WRITE_FIX_CHOP    = 3'h3,
        CMD_WRITE_FIX_FULL    = 3'h4,
        CMD_WRITE_AP_FIX_CHOP = 3'h5,
        CMD_WRITE_AP_FIX_FULL = 3'h6,
        CMD_READ              = 3'h7
    } cmd_t;

    typedef enum logic [1:0] {
        BURST_FULL = 2'h0,
        BURST_OTF  = 2'h1,
        BURST_CHOP = 2'h2
    } burst_mode_t;

    typedef struct packed {
        logic pin;
        logic wr_full;
        logic wr_chop;
        logic rd;
    } lane_t;

    typedef struct packed {
        logic [7:0] dlat;
        logic [7:0] roff;
        logic [7:0] ron;
        logic [7:0] cnw;
        logic [7:0] cwn4;
        logic [7:0] cwn8;
    } lat_t;

endpackage

// ===== hw/lane_history.sv
// Shift line holding one lane sample per link clock cycle.
// Assumes shift_i is a one-cycle pulse per link clock rising edge.
`timescale 1ns/1ps

module lane_history #(
    parameter int DEPTH = 64,
    parameter int WIDTH = 4
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_b_i,
    input  wire logic                         shift_i,
    input  wire logic [WIDTH-1:0]             din_i,
    output logic      [DEPTH-1:0][WIDTH-1:0]  hist_o
);

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
        $error("lane_history: DEPTH or WIDTH too small");
    end

    // Index 0 is the newest link cycle
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            hist_o <= '0;
        end else if (shift_i) begin
            hist_o <= {hist_o[DEPTH-2:0], din_i};
        end
    end

endmodule

// ===== hw/sync_dynamic_termination_ctrl.sv
// Termination control of the memory die: latency windows and AXI4-Lite config.
// Assumes link clock, pin and command arrive unsynchronised, far slower than clk_i.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "term_regs.svh"

module sync_dynamic_termination_ctrl #(
    parameter int DEPTH = 64
) (
    input  wire logic               clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               ck_i,
    input  wire logic               termination_ctrl_pin_i,
    input  wire logic [2:0]         cmd_i,
    input  wire logic               awvalid_i,
    output logic                    awready_o,
    input  wire logic [7:0]         awaddr_i,
    input  wire logic               wvalid_i,
    output logic                    wready_o,
    input  wire logic [31:0]        wdata_i,
    input  wire logic [3:0]         wstrb_i,
    output logic                    bvalid_o,
    input  wire logic               bready_i,
    output logic [1:0]              bresp_o,
    input  wire logic               arvalid_i,
    output logic                    arready_o,
    input  wire logic [7:0]         araddr_i,
    output logic                    rvalid_o,
    input  wire logic               rready_i,
    output logic [31:0]             rdata_o,
    output logic [1:0]              rresp_o,
    output term_pkg::term_sel_t     term_sel_o,
    output logic [2:0]              term_value_o
);

    if (DEPTH < 16 || DEPTH > 256) begin : g_bad
        $error("DEPTH must lie in 16..256");
    end

    localparam int LW = $bits(term_pkg::lane_t);

    logic [4:0]                 sync1_r;
    logic [4:0]                 sync2_r;
    logic                       ck_prev_r;
    logic                       tick;
    logic                       pin_s;
    term_pkg::cmd_t             cmd_s;
    logic [31:0]                mode1_r;
    logic [31:0]                mode2_r;
    logic [31:0]                mode5_r;
    logic [31:0]                lat_reg_r;
    logic [31:0]                ctrl_r;
    term_pkg::burst_mode_t      burst;
    logic                       is_wr;
    logic                       chop;
    term_pkg::lane_t            lane_in;
    logic [DEPTH-1:0][LW-1:0]   hist_w;
    term_pkg::lat_t             lat_nxt;
    term_pkg::lat_t             lat_r;
    logic [7:0]                 sum_w;
    logic [7:0]                 sum_r;
    logic [7:0]                 pre;
    logic [7:0]                 extra;
    logic [DEPTH-1:0]           rd_hit;
    logic [DEPTH-1:0]           wr_hit;
    logic [DEPTH-1:0]           pin_at;
    logic                       dll;
    logic                       srf;
    logic                       nom_en;
    logic                       dyn_on;
    logic                       rd_off;
    logic                       wr_on;
    logic                       nom_on;
    term_pkg::term_sel_t        sel_nxt;
    logic [2:0]                 value_nxt;

    // Two stages before anything looks at the link signals
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sync1_r   <= 5'h00;
            sync2_r   <= 5'h00;
            ck_prev_r <= 1'b0;
        end else begin
            sync1_r   <= {ck_i, termination_ctrl_pin_i, cmd_i};
            sync2_r   <= sync1_r;
            ck_prev_r <= sync2_r[4];
        end
    end

    assign tick  = sync2_r[4] & ~ck_prev_r;
    assign pin_s = sync2_r[3];
    assign cmd_s = term_pkg::cmd_t'(sync2_r[2:0]);
    assign burst = term_pkg::burst_mode_t'(ctrl_r[`CTL_BURST_LSB +: 2]);
    assign dll   = ctrl_r[`CTL_DLL];
    assign srf   = ctrl_r[`CTL_SRF];

    // Fixed-length variants override the mode; plain writes follow it
    always_comb begin
        is_wr = 1'b1;
        chop  = 1'b0;
        case (cmd_s)
            term_pkg::CMD_WRITE, term_pkg::CMD_WRITE_AP: begin
                chop = (burst == term_pkg::BURST_CHOP);
            end
            term_pkg::CMD_WRITE_FIX_CHOP, term_pkg::CMD_WRITE_AP_FIX_CHOP: begin
                chop = 1'b1;
            end
            term_pkg::CMD_WRITE_FIX_FULL, term_pkg::CMD_WRITE_AP_FIX_FULL: begin
                chop = 1'b0;
            end
            default: begin
                is_wr = 1'b0;
            end
        endcase
        lane_in.pin     = pin_s;
        lane_in.wr_full = is_wr & ~chop;
        lane_in.wr_chop = is_wr & chop;
        lane_in.rd      = (cmd_s == term_pkg::CMD_READ);
    end

    lane_history #(
        .DEPTH (DEPTH),
        .WIDTH (LW)
    ) u_hist (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .shift_i (tick),
        .din_i   (lane_in),
        .hist_o  (hist_w)
    );

    function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [7:0] b);
        return (a >= b) ? a - b : 8'h00;
    endfunction

    // Latencies in link cycles; too short a setting clamps at zero
    always_comb begin
        sum_w = {2'b00, lat_reg_r[`CAS_WR_LAT_LSB +: 6]} + {2'b00, lat_reg_r[`ADD_LAT_LSB +: 6]}
              + {2'b00, lat_reg_r[`PAR_LAT_LSB +: 6]};
        sum_r = {2'b00, lat_reg_r[`CAS_LAT_LSB +: 6]} + {2'b00, lat_reg_r[`ADD_LAT_LSB +: 6]}
              + {2'b00, lat_reg_r[`PAR_LAT_LSB +: 6]};
        pre   = ctrl_r[`CTL_PRE2] ? `PRE2_SUB : `PRE1_SUB;
        extra = ctrl_r[`CTL_PRE2] ? `PRE2_EXTRA : 8'h00;
        lat_nxt.dlat = sat_sub(sum_w, pre);
        lat_nxt.cnw  = sat_sub(sum_w, pre);
        lat_nxt.roff = sat_sub(sum_r, pre);
        lat_nxt.ron  = lat_nxt.roff + extra
                     + ((burst == term_pkg::BURST_CHOP) ? `RD_RESTORE_CHOP : `RD_RESTORE_FULL);
        lat_nxt.cwn4 = lat_nxt.cnw + extra
                     + (ctrl_r[`CTL_CRC] ? `WR_CHOP_ADD_CRC : `WR_CHOP_ADD);
        lat_nxt.cwn8 = lat_nxt.cnw + extra
                     + (ctrl_r[`CTL_CRC] ? `WR_FULL_ADD_CRC : `WR_FULL_ADD);
    end

    // No reset: tracks the registers in reset too, so no stale zero after release
    always_ff @(posedge clk_i) begin
        lat_r <= lat_nxt;
    end

    // Window test per history slot
    for (genvar k = 0; k < DEPTH; k++) begin : g_win
        localparam logic [7:0] K = 8'(k);
        term_pkg::lane_t ln;
        assign ln        = term_pkg::lane_t'(hist_w[k]);
        assign rd_hit[k] = ln.rd && K >= lat_r.roff && K < lat_r.ron;
        assign wr_hit[k] = K >= lat_r.cnw && ((ln.wr_full && K < lat_r.cwn8)
                         || (ln.wr_chop && K < lat_r.cwn4));
        assign pin_at[k] = ln.pin && (K == lat_r.dlat);
    end

    // Unlocked loop: no latency pipeline, pin taken as sampled
    assign nom_en = (mode1_r[`NOM_FIELD_LSB +: 3] != 3'h0) && !srf;
    assign dyn_on = (mode2_r[`DYN_BIT_A] | mode2_r[`DYN_BIT_B]) & dll;
    assign rd_off = |rd_hit;
    assign wr_on  = dyn_on & (|wr_hit);
    assign nom_on = nom_en & (dll ? |pin_at : pin_s);

    always_comb begin
        sel_nxt   = term_pkg::TERM_OFF;
        value_nxt = 3'h0;
        if (srf || rd_off) begin
            sel_nxt = term_pkg::TERM_OFF;
        end else if (wr_on) begin
            sel_nxt   = term_pkg::TERM_WR;
            value_nxt = mode2_r[`WR_FIELD_LSB +: 3];
        end else if (nom_on) begin
            sel_nxt   = term_pkg::TERM_NOM;
            value_nxt = mode1_r[`NOM_FIELD_LSB +: 3];
        end else if (mode5_r[`PARK_FIELD_LSB +: 3] != 3'h0) begin
            sel_nxt   = term_pkg::TERM_PARK;
            value_nxt = mode5_r[`PARK_FIELD_LSB +: 3];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            term_sel_o   <= term_pkg::TERM_OFF;
            term_value_o <= 3'h0;
        end else begin
            term_sel_o   <= sel_nxt;
            term_value_o <= value_nxt;
        end
    end

    // AXI4-Lite slave: one write and one read outstanding
    logic           aw_fire;
    logic           w_fire;
    logic           wr_go;
    logic           wr_mapped;
    logic [7:0]     awaddr_r;
    logic [31:0]    wdata_r;
    logic [3:0]     wstrb_r;
    logic [31:0]    rdata_nxt;
    logic [1:0]     rresp_nxt;
    logic [31:0]    status_w;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                res[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return res;
    endfunction

    assign aw_fire = awvalid_i & awready_o;
    assign w_fire  = wvalid_i & wready_o;
    assign wr_go   = !awready_o && !wready_o && !bvalid_o;

    always_comb begin
        case ({awaddr_r[7:2], 2'b00})
            `OFS_MODE_ONE, `OFS_MODE_TWO, `OFS_MODE_FIVE,
            `OFS_LATENCY, `OFS_CONTROL, `OFS_STATUS: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            awready_o <= 1'b1;
            wready_o  <= 1'b1;
            bvalid_o  <= 1'b0;
            bresp_o   <= `RESP_OKAY;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (aw_fire) begin
                awready_o <= 1'b0;
                awaddr_r  <= awaddr_i;
            end
            if (w_fire) begin
                wready_o <= 1'b0;
                wdata_r  <= wdata_i;
                wstrb_r  <= wstrb_i;
            end
            if (wr_go) begin
                bvalid_o <= 1'b1;
                bresp_o  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid_o && bready_i) begin
                bvalid_o  <= 1'b0;
                awready_o <= 1'b1;
                wready_o  <= 1'b1;
            end
        end
    end

    // Mode fields are copies of the die's mode registers
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mode1_r   <= `RST_MODE;
            mode2_r   <= `RST_MODE;
            mode5_r   <= `RST_MODE;
            lat_reg_r <= `RST_LATENCY;
            ctrl_r    <= `RST_CONTROL;
        end else if (wr_go) begin
            case ({awaddr_r[7:2], 2'b00})
                `OFS_MODE_ONE:  mode1_r   <= merge(mode1_r, wdata_r, wstrb_r) & `MASK_MODE;
                `OFS_MODE_TWO:  mode2_r   <= merge(mode2_r, wdata_r, wstrb_r) & `MASK_MODE;
                `OFS_MODE_FIVE: mode5_r   <= merge(mode5_r, wdata_r, wstrb_r) & `MASK_MODE;
                `OFS_LATENCY:   lat_reg_r <= merge(lat_reg_r, wdata_r, wstrb_r) & `MASK_LATENCY;
                `OFS_CONTROL:   ctrl_r    <= merge(ctrl_r, wdata_r, wstrb_r) & `MASK_CONTROL;
                default: begin
                end
            endcase
        end
    end

    assign status_w = {21'h0, wr_on, rd_off, dyn_on, 3'h0, term_value_o, term_sel_o};

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = `RESP_OKAY;
        case ({araddr_i[7:2], 2'b00})
            `OFS_MODE_ONE:  rdata_nxt = mode1_r;
            `OFS_MODE_TWO:  rdata_nxt = mode2_r;
            `OFS_MODE_FIVE: rdata_nxt = mode5_r;
            `OFS_LATENCY:   rdata_nxt = lat_reg_r;
            `OFS_CONTROL:   rdata_nxt = ctrl_r;
            `OFS_STATUS:    rdata_nxt = status_w;
            default:        rresp_nxt = `RESP_SLVERR;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            arready_o <= 1'b1;
            rvalid_o  <= 1'b0;
            rdata_o   <= 32'h0000_0000;
            rresp_o   <= `RESP_OKAY;
        end else if (arvalid_i && arready_o) begin
            arready_o <= 1'b0;
            rvalid_o  <= 1'b1;
            rdata_o   <= rdata_nxt;
            rresp_o   <= rresp_nxt;
        end else if (rvalid_o && rready_i) begin
            arready_o <= 1'b1;
            rvalid_o  <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_wr_cmd;
        tick && is_wr;
    endsequence
    sequence s_lat_settled;
        $stable(ctrl_r) && $stable(lat_reg_r) [*2];
    endsequence

    property p_srf_off;
        srf |=> term_sel_o == term_pkg::TERM_OFF;
    endproperty
    a_srf_off: assert property (p_srf_off) else $error("termination on in self refresh");

    property p_rd_off;
        (rd_off && !srf) |=> term_sel_o == term_pkg::TERM_OFF && term_value_o == 3'h0;
    endproperty
    a_rd_off: assert property (p_rd_off) else $error("termination during read");

    property p_wr_first;
        (wr_on && !rd_off && !srf) |=> term_sel_o == term_pkg::TERM_WR;
    endproperty
    a_wr_first: assert property (p_wr_first) else $error("write termination lost");

    property p_nom;
        (nom_on && !wr_on && !rd_off) |=> term_sel_o == term_pkg::TERM_NOM;
    endproperty
    a_nom: assert property (p_nom) else $error("nominal not applied");

    property p_dyn_gate;
        !dyn_on |=> term_sel_o != term_pkg::TERM_WR;
    endproperty
    a_dyn_gate: assert property (p_dyn_gate) else $error("write termination while disabled");

    property p_wr_value;
        term_sel_o == term_pkg::TERM_WR |-> term_value_o == $past(mode2_r[`WR_FIELD_LSB +: 3]);
    endproperty
    a_wr_value: assert property (p_wr_value) else $error("write value wrong");

    property p_wr_capture;
        s_wr_cmd |=> (g_win[0].ln.wr_full || g_win[0].ln.wr_chop);
    endproperty
    a_wr_capture: assert property (p_wr_capture) else $error("write not recorded");

    property p_direct_lat;
        s_lat_settled |-> lat_r.dlat + pre == sum_w || (sum_w < pre && lat_r.dlat == 8'h00);
    endproperty
    a_direct_lat: assert property (p_direct_lat) else $error("direct latency wrong");

    property p_deselect_gap;
        s_lat_settled |-> lat_r.cwn8 - lat_r.cnw
            == (ctrl_r[`CTL_CRC] ? 8'h07 : 8'h06) + extra;
    endproperty
    a_deselect_gap: assert property (p_deselect_gap) else $error("deselect latency wrong");

    property p_restore_gap;
        s_lat_settled |-> lat_r.ron - lat_r.roff
            == ((burst == term_pkg::BURST_CHOP) ? 8'h04 : 8'h06) + extra;
    endproperty
    a_restore_gap: assert property (p_restore_gap) else $error("restore latency wrong");

endmodule

// ===== verif/ctrl_model.sv
// Controller stand-in: free-running link clock, termination pin and commands.
// Assumes go_i is held across exactly one falling link edge per event.
`timescale 1ns/1ps

module ctrl_model (
    input  wire logic           go_i,
    input  wire logic [4:0]     len_i,
    input  wire term_pkg::cmd_t cmd_i,
    output logic                ck_o,
    output logic                pin_o,
    output term_pkg::cmd_t      cmd_o,
    output logic [15:0]         cnt_o
);
    logic [4:0] left_r;

    initial begin
        ck_o = 1'b0;
        pin_o = 1'b0;
        cmd_o = term_pkg::CMD_NOP;
        cnt_o = 16'h0000;
        left_r = 5'h00;
        #7;
        forever #100 ck_o = ~ck_o;
    end

    always @(posedge ck_o) cnt_o <= cnt_o + 16'h0001;

    // Falling edge changes keep each value stable over a whole link cycle
    always @(negedge ck_o) begin
        cmd_o <= go_i ? cmd_i : term_pkg::CMD_NOP;
        if (go_i && len_i != 5'h00) begin
            pin_o <= 1'b1;
            left_r <= (len_i < 5'h06) ? 5'h06 : len_i;
        end else begin
            pin_o <= (left_r > 5'h01);
            left_r <= (left_r != 5'h00) ? left_r - 5'h01 : 5'h00;
        end
    end
endmodule

// ===== verif/tb.sv
// Bench: AXI4-Lite register checks, then termination windows on the link.
// Assumes DEPTH 32 covers every latency set here.
`timescale 1ns/1ps
`include "term_regs.svh"

module tb;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] w;
        logic [3:0]  s;
        logic [31:0] r;
        logic [1:0]  resp;
    } reg_row_t;
    // Sample points k and sel codes s, earliest in the top element
    typedef struct packed {
        logic [7:0]      ctl;
        logic [15:0]     m2;
        logic [4:0]      len;
        logic [2:0]      cmd;
        logic [3:0][7:0] k;
        logic [3:0][1:0] s;
    } link_row_t;

    logic                clk;
    logic                rst_b = 1'b0;
    logic                ck, pin, go = 1'b0;
    logic [4:0]          len = 5'h00;
    term_pkg::cmd_t      cmd_req = term_pkg::CMD_NOP;
    term_pkg::cmd_t      cmd;
    logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic                arvalid = 1'b0, rready = 1'b0;
    logic                awready, wready, bvalid, arready, rvalid;
    logic [7:0]          awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]         wdata = 32'h0, rdata, rd;
    logic [3:0]          wstrb = 4'h0;
    logic [1:0]          bresp, rresp, rsp;
    logic [15:0]         cnt, t;
    logic [2:0]          tval;
    term_pkg::term_sel_t sel;
    int                  fails = 0, checks = 0;
    link_row_t           lr;

    reg_row_t rrows [6] = '{
        '{8'h00, 32'hFFFFFFFF, 4'hF, 32'h00003FFF, `RESP_OKAY},
        '{8'h14, 32'hFFFFFFFF, 4'hF, 32'h00000000, `RESP_OKAY},
        '{8'h0C, 32'hFFFFFFFF, 4'hF, 32'h3F3F3F3F, `RESP_OKAY},
        '{8'h10, 32'hFFFFFFFF, 4'hF, 32'h0000003F, `RESP_OKAY},
        '{8'h08, 32'hFFFFFFFF, 4'h1, 32'h000000FF, `RESP_OKAY},
        '{8'h18, 32'hFFFFFFFF, 4'hF, 32'h00000000, `RESP_SLVERR}};
    link_row_t lrows [21] = '{
        '{8'h10, 16'h0600, 5'h08, 3'h0, 32'h06070E0F, 8'hD7},
        '{8'h10, 16'h0600, 5'h00, 3'h1, 32'h06070C0D, 8'hEB},
        '{8'h10, 16'h0600, 5'h00, 3'h2, 32'h06070C0D, 8'hEB},
        '{8'h10, 16'h0600, 5'h00, 3'h4, 32'h06070C0D, 8'hEB},
        '{8'h10, 16'h0600, 5'h00, 3'h6, 32'h06070C0D, 8'hEB},
        '{8'h10, 16'h0600, 5'h00, 3'h3, 32'h06070A0B, 8'hEB},
        '{8'h10, 16'h0600, 5'h00, 3'h5, 32'h06070A0B, 8'hEB},
        '{8'h10, 16'h0600, 5'h00, 3'h7, 32'h08090E0F, 8'hC3},
        '{8'h18, 16'h0600, 5'h00, 3'h7, 32'h08090C0D, 8'hC3},
        '{8'h14, 16'h0600, 5'h00, 3'h7, 32'h08090E0F, 8'hC3},
        '{8'h12, 16'h0600, 5'h00, 3'h3, 32'h06070D0E, 8'hEB},
        '{8'h12, 16'h0600, 5'h00, 3'h1, 32'h06070D0E, 8'hEB},
        '{8'h13, 16'h0600, 5'h00, 3'h3, 32'h05060D0E, 8'hEB},
        '{8'h11, 16'h0600, 5'h08, 3'h0, 32'h05060D0E, 8'hD7},
        '{8'h11, 16'h0600, 5'h00, 3'h1, 32'h05060C0D, 8'hEB},
        '{8'h11, 16'h0600, 5'h00, 3'h7, 32'h07080E0F, 8'hC3},
        '{8'h10, 16'h0600, 5'h0A, 3'h1, 32'h06070C0D, 8'hE9},
        '{8'h10, 16'h0400, 5'h00, 3'h1, 32'h06070C0D, 8'hEB},
        '{8'h10, 16'h0000, 5'h00, 3'h1, 32'h06070C0D, 8'hFF},
        '{8'h00, 16'h0600, 5'h00, 3'h1, 32'h06070C0D, 8'hFF},
        '{8'h30, 16'h0600, 5'h08, 3'h0, 32'h06070E0F, 8'h00}};
    logic [31:0] rst_vals [5] = '{`RST_MODE, `RST_MODE, `RST_MODE, `RST_LATENCY, `RST_CONTROL};

    sync_dynamic_termination_ctrl #(.DEPTH(32)) dut (
        .clk_i(clk), .rst_b_i(rst_b), .ck_i(ck), .termination_ctrl_pin_i(pin), .cmd_i(cmd),
        .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr), .wvalid_i(wvalid),
        .wready_o(wready), .wdata_i(wdata), .wstrb_i(wstrb), .bvalid_o(bvalid),
        .bready_i(bready), .bresp_o(bresp), .arvalid_i(arvalid), .arready_o(arready),
        .araddr_i(araddr), .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata),
        .rresp_o(rresp), .term_sel_o(sel), .term_value_o(tval));

    ctrl_model model (.go_i(go), .len_i(len), .cmd_i(cmd_req), .ck_o(ck), .pin_o(pin),
        .cmd_o(cmd), .cnt_o(cnt));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        if (fails == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Address and data released separately, each on its own acceptance
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_on;
        logic w_on;
        aw_on = 1'b1;
        w_on = 1'b1;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        while (aw_on || w_on) begin
            @(posedge clk);
            if (aw_on && awready) begin
                aw_on = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_on && wready) begin
                w_on = 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        arvalid <= 1'b1;
        araddr <= a;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    function automatic logic [2:0] exp_val(input logic [1:0] s, input logic [15:0] m2);
        case (s)
            2'h1: return 3'h2;
            2'h2: return m2[11:9];
            2'h3: return 3'h5;
            default: return 3'h0;
        endcase
    endfunction

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Rows take about 210 clocks each; this is far beyond the whole run
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rrows[i]) begin
            axi_wr(rrows[i].a, rrows[i].w, rrows[i].s);
            chk("bresp", rsp, rrows[i].resp);
            axi_rd(rrows[i].a);
            chk("rdata", rd, rrows[i].r);
            chk("rresp", rsp, rrows[i].resp);
        end
        axi_wr(8'h00, 32'h00000200, 4'hF);
        axi_wr(8'h08, 32'h00000140, 4'hF);
        axi_wr(8'h0C, `RST_LATENCY, 4'hF);
        foreach (lrows[i]) begin
            lr = lrows[i];
            axi_wr(8'h10, {24'h0, lr.ctl}, 4'hF);
            axi_wr(8'h04, {16'h0, lr.m2}, 4'hF);
            @(posedge ck);
            @(posedge clk);
            go <= 1'b1;
            len <= lr.len;
            cmd_req <= term_pkg::cmd_t'(lr.cmd);
            @(negedge ck);
            @(posedge clk);
            go <= 1'b0;
            t = cnt + 16'h0001;
            for (int j = 3; j >= 0; j--) begin
                while (cnt < t + 16'(lr.k[j])) @(posedge clk);
                // Past the sync and output pipeline, well before the next change
                repeat (7) @(posedge clk);
                chk("term_sel", sel, lr.s[j]);
                chk("term_value", tval, exp_val(lr.s[j], lr.m2));
            end
            while (cnt < t + 16'h0018) @(posedge clk);
        end
        rst_b <= 1'b0;
        repeat (6) @(posedge clk);
        chk("term_sel", sel, 32'h0);
        chk("awready", awready, 32'h1);
        chk("wready", wready, 32'h1);
        chk("arready", arready, 32'h1);
        chk("bvalid", bvalid, 32'h0);
        chk("rvalid", rvalid, 32'h0);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rst_vals[i]) begin
            axi_rd(8'(i * 4));
            chk("reset value", rd, rst_vals[i]);
        end
        summarize();
    end
endmodule
